// ==== hw/gain_switch_consts.svh ====
`ifndef GAIN_SWITCH_CONSTS_SVH
`define GAIN_SWITCH_CONSTS_SVH

// one parameter word
`define GS_WORD_W       16
// switching selection: source in digit 0, polarity in digit 1
`define GS_SRC_LSB      0
`define GS_POL_LSB      4
`define GS_DIGIT_W      4
`define GS_SRC_OFF      4'h0
`define GS_SRC_INPUT    4'h1
`define GS_SRC_FREQ     4'h2
`define GS_SRC_DROOP    4'h3
`define GS_SRC_SPEED    4'h4
`define GS_POL_GE       4'h0
`define GS_POL_LE       4'h1
// filter time base
`define GS_CLK_PERIOD_NS 100
`define GS_MS_NS         1000000
`define GS_FRAC_W        8
`define GS_TC_ZERO       16'h0000

`endif

// ==== hw/gain_switch_pkg.sv ====
`include "gain_switch_consts.svh"

package gain_switch_pkg;

    typedef logic [`GS_WORD_W-1:0] param_word_t;

    localparam int NUM_PARAMS = 13;

    typedef struct packed {
        param_word_t inertia_ratio;
        param_word_t model_loop_gain;
        param_word_t position_loop_gain;
        param_word_t speed_loop_gain;
        param_word_t integral_comp;
        param_word_t vib1_frequency;
        param_word_t vib1_resonance;
        param_word_t vib1_vib_damping;
        param_word_t vib1_res_damping;
        param_word_t vib2_frequency;
        param_word_t vib2_resonance;
        param_word_t vib2_vib_damping;
        param_word_t vib2_res_damping;
    } gain_set_s;

    typedef param_word_t [NUM_PARAMS-1:0] gain_array_t;

endpackage

// ==== hw/gain_lag_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gain_switch_consts.svh"

module gain_lag_filter
#(
    parameter int W = `GS_WORD_W,
    parameter int F = `GS_FRAC_W
)
(
    input  wire logic         mclk_i,
    input  wire logic         rst_b_i,
    input  wire logic         tick_i,
    input  wire logic [15:0]  tc_i,
    input  wire logic [W-1:0] target_i,
    output logic      [W-1:0] value_o
);

    logic        [W+F-1:0] acc_reg;
    logic        [W+F-1:0] acc_next;
    logic signed [W+F:0]   diff;
    logic signed [W+F:0]   step;

    // one step per millisecond: y += (x - y) / T, a first-order lag of T ms
    always_comb
    begin
        diff     = $signed({1'b0, target_i, {F{1'b0}}}) - $signed({1'b0, acc_reg});
        step     = diff / $signed({{(W+F-16){1'b0}}, 1'b0, tc_i});
        acc_next = acc_reg;
        if (tick_i)
        begin
            // snapping when the step rounds to zero keeps the lag from stalling short
            if (tc_i == `GS_TC_ZERO || step == '0)
                acc_next = {target_i, {F{1'b0}}};
            else
                acc_next = (W+F)'($signed({1'b0, acc_reg}) + step);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
            acc_reg <= '0;
        else
            acc_reg <= acc_next;
    end

    assign value_o = acc_reg[W+F-1:F];

endmodule
`default_nettype wire

// ==== hw/servo_gain_set_switcher.sv ====
// Summary of operation
// - source code 0 off,1 input,2 freq,3 droop,4 speed
// - source digit one, polarity digit two
// - polarity 0: alternate when quantity at/above level
// - polarity 1: alternate when quantity at/below level
// - level compared only for freq, droop, speed
// - switched values pass first-order ms lag filter
// - switching replaces inertia, position, speed and integral values with alternate; input source replaces every value
// - vibration and model gain switch only by input
`timescale 1ns/1ps
`default_nettype none
`include "gain_switch_consts.svh"

module servo_gain_set_switcher
#(
    parameter int QW        = 16,
    parameter int MS_CYCLES = `GS_MS_NS / `GS_CLK_PERIOD_NS
)
(
    input  wire logic                       mclk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [15:0]                switch_function_param_i,
    input  wire logic [QW-1:0]              gain_switch_level_i,
    input  wire logic [15:0]                gain_switch_time_constant_i,
    input  wire logic                       gain_switch_input_i,
    input  wire logic [QW-1:0]              command_freq_i,
    input  wire logic [QW-1:0]              droop_pulses_i,
    input  wire logic [QW-1:0]              motor_speed_i,
    input  wire gain_switch_pkg::gain_set_s normal_set_i,
    input  wire gain_switch_pkg::gain_set_s alternate_set_i,
    output var gain_switch_pkg::gain_set_s  active_set_o,
    output logic                            alternate_active_o
);
    import gain_switch_pkg::*;

    localparam int CW = $clog2(MS_CYCLES + 1);

    logic [`GS_DIGIT_W-1:0] src_sel;
    logic [`GS_DIGIT_W-1:0] pol_sel;
    logic [QW-1:0]          quantity;
    logic                   use_level;
    logic                   cond;
    logic                   pin_meta_reg;
    logic                   pin_sync_reg;
    logic                   alt_reg;
    logic                   alt_next;
    logic                   src_input_reg;
    logic                   src_input_next;
    logic [CW-1:0]          ms_cnt_reg;
    logic [CW-1:0]          ms_cnt_next;
    logic                   tick_reg;
    logic                   tick_next;
    gain_set_s              target;
    gain_array_t            target_arr;
    gain_array_t            active_arr;

    // external pin comes from another domain
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end
        else
        begin
            pin_meta_reg <= gain_switch_input_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_comb
    begin
        src_sel   = switch_function_param_i[`GS_SRC_LSB +: `GS_DIGIT_W];
        pol_sel   = switch_function_param_i[`GS_POL_LSB +: `GS_DIGIT_W];
        quantity  = '0;
        use_level = 1'b0;
        case (src_sel)
            `GS_SRC_FREQ:
            begin
                quantity  = command_freq_i;
                use_level = 1'b1;
            end
            `GS_SRC_DROOP:
            begin
                quantity  = droop_pulses_i;
                use_level = 1'b1;
            end
            `GS_SRC_SPEED:
            begin
                quantity  = motor_speed_i;
                use_level = 1'b1;
            end
            default:
            begin
                quantity  = '0;
                use_level = 1'b0;
            end
        endcase
        if (src_sel == `GS_SRC_INPUT)
            cond = pin_sync_reg;
        else if (!use_level)
            cond = 1'b0;
        else if (pol_sel == `GS_POL_LE)
            cond = quantity <= gain_switch_level_i;
        else
            cond = quantity >= gain_switch_level_i;
        alt_next       = cond;
        src_input_next = (src_sel == `GS_SRC_INPUT);
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            alt_reg       <= 1'b0;
            src_input_reg <= 1'b0;
        end
        else
        begin
            alt_reg       <= alt_next;
            src_input_reg <= src_input_next;
        end
    end

    // the vibration and model terms are only swapped while the input source is chosen
    always_comb
    begin
        target = normal_set_i;
        if (alt_reg)
        begin
            target.inertia_ratio      = alternate_set_i.inertia_ratio;
            target.position_loop_gain = alternate_set_i.position_loop_gain;
            target.speed_loop_gain    = alternate_set_i.speed_loop_gain;
            target.integral_comp      = alternate_set_i.integral_comp;
            if (src_input_reg)
            begin
                target.model_loop_gain  = alternate_set_i.model_loop_gain;
                target.vib1_frequency   = alternate_set_i.vib1_frequency;
                target.vib1_resonance   = alternate_set_i.vib1_resonance;
                target.vib1_vib_damping = alternate_set_i.vib1_vib_damping;
                target.vib1_res_damping = alternate_set_i.vib1_res_damping;
                target.vib2_frequency   = alternate_set_i.vib2_frequency;
                target.vib2_resonance   = alternate_set_i.vib2_resonance;
                target.vib2_vib_damping = alternate_set_i.vib2_vib_damping;
                target.vib2_res_damping = alternate_set_i.vib2_res_damping;
            end
        end
        target_arr = target;
    end

    // millisecond enable for the lag filters
    always_comb
    begin
        tick_next   = 1'b0;
        ms_cnt_next = ms_cnt_reg + CW'(1);
        if (ms_cnt_reg == CW'(MS_CYCLES - 1))
        begin
            ms_cnt_next = '0;
            tick_next   = 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            ms_cnt_reg <= '0;
            tick_reg   <= 1'b0;
        end
        else
        begin
            ms_cnt_reg <= ms_cnt_next;
            tick_reg   <= tick_next;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PARAMS; gi++)
        begin : g_lag
            gain_lag_filter u_lag
            (
                .mclk_i   (mclk_i),
                .rst_b_i  (rst_b_i),
                .tick_i   (tick_reg),
                .tc_i     (gain_switch_time_constant_i),
                .target_i (target_arr[gi]),
                .value_o  (active_arr[gi])
            );
        end
    endgenerate

    assign active_set_o       = active_arr;
    assign alternate_active_o = alt_reg;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_src_off: assert property ((src_sel == `GS_SRC_OFF) |=> !alternate_active_o)
        else $error("alternate set active with switching disabled");
    a_digit_pin: assert property ((src_sel == `GS_SRC_INPUT)
        |=> alternate_active_o == $past(pin_sync_reg))
        else $error("input source did not follow synchronised pin");
    a_ge_level: assert property (use_level && pol_sel == `GS_POL_GE
        && quantity >= gain_switch_level_i |=> alternate_active_o)
        else $error("at-or-above condition did not select alternate set");
    a_le_level: assert property (use_level && pol_sel == `GS_POL_LE
        && quantity <= gain_switch_level_i |=> alternate_active_o)
        else $error("at-or-below condition did not select alternate set");
    a_freq_below: assert property (src_sel == `GS_SRC_FREQ && pol_sel == `GS_POL_GE
        && command_freq_i < gain_switch_level_i |=> !alternate_active_o)
        else $error("frequency below level selected alternate set");
    a_lag_hold: assert property (!tick_reg |=> $stable(active_set_o))
        else $error("filtered output moved without a millisecond tick");
    a_lag_direct: assert property (tick_reg
        && gain_switch_time_constant_i == `GS_TC_ZERO |=> active_set_o == $past(target))
        else $error("zero time constant did not load target at once");
    a_alt_full: assert property (alt_reg && src_input_reg |-> target == alternate_set_i)
        else $error("input switching left a normal value in place");
    a_vib_normal: assert property (!src_input_reg
        |-> target.model_loop_gain == normal_set_i.model_loop_gain
        && target.vib2_res_damping == normal_set_i.vib2_res_damping)
        else $error("vibration or model gain switched by level source");
    a_normal_set: assert property (!alt_reg |-> target == normal_set_i)
        else $error("normal set not used while condition absent");

    c_input_switch: cover property (src_input_reg && $rose(alternate_active_o));
    c_speed_switch: cover property (src_sel == `GS_SRC_SPEED && $rose(alternate_active_o));
    c_return: cover property ($fell(alternate_active_o));

endmodule
`default_nettype wire

// ==== tb/gain_switch_driver.sv ====
`timescale 1ns/1ps
`default_nettype none

module gain_switch_driver
(
    input  wire logic       mclk_i,
    input  wire logic       request_i,
    input  wire logic [3:0] lag_i,
    output logic            pin_o
);
    logic [3:0] count;

    initial pin_o = 1'b0;
    initial count = 4'h0;

    // the controller is not tied to our clock, so the pin moves mid-period
    // lag_i stretches its reaction to mimic a slow controller
    always @(negedge mclk_i)
    begin
        if (request_i == pin_o)
            count <= 4'h0;
        else if (count >= lag_i)
        begin
            pin_o <= request_i;
            count <= 4'h0;
        end
        else
            count <= count + 4'h1;
    end
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
    import gain_switch_pkg::*;

    typedef struct {
        logic [15:0] func;
        logic [15:0] level;
        logic [15:0] freq;
        logic [15:0] droop;
        logic [15:0] speed;
        logic        pin;
        logic        alt;
    } row_s;

    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [15:0] func = 16'h0000;
    logic [15:0] level = 16'h0000;
    logic [15:0] tc = 16'h0000;
    logic [15:0] freq = 16'h0000;
    logic [15:0] droop = 16'h0000;
    logic [15:0] speed = 16'h0000;
    logic        request = 1'b0;
    logic [3:0]  lag = 4'h0;
    logic        pin;
    gain_set_s   normal_set;
    gain_set_s   alt_set;
    gain_set_s   active_set;
    logic        alt_active;
    gain_array_t nv;
    gain_array_t av;
    int          miscompares = 0;
    int          comparisons = 0;
    row_s        rows [12];
    int          i;

    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end

    gain_switch_driver gain_switch_driver_i (.mclk_i(mclk_i), .request_i(request),
        .lag_i(lag), .pin_o(pin));

    servo_gain_set_switcher #(.QW(16), .MS_CYCLES(4)) servo_gain_set_switcher_i (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .switch_function_param_i(func),
        .gain_switch_level_i(level), .gain_switch_time_constant_i(tc),
        .gain_switch_input_i(pin), .command_freq_i(freq), .droop_pulses_i(droop),
        .motor_speed_i(speed), .normal_set_i(normal_set), .alternate_set_i(alt_set),
        .active_set_o(active_set), .alternate_active_o(alt_active));

    task automatic stop_test();
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_set(input gain_set_s got, input gain_set_s exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // only the pin source may move the model gain and vibration fields
    function automatic gain_set_s exp_set(input logic alt, input logic by_pin);
        gain_set_s s;
        s = normal_set;
        if (alt && by_pin)
            s = alt_set;
        else if (alt)
        begin
            s.inertia_ratio = alt_set.inertia_ratio;
            s.position_loop_gain = alt_set.position_loop_gain;
            s.speed_loop_gain = alt_set.speed_loop_gain;
            s.integral_comp = alt_set.integral_comp;
        end
        return s;
    endfunction

    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_i);
        #10;
    endtask

    // bounded wait on the inertia field, which every source switches
    task automatic wait_inertia(input logic [15:0] v, input logic equal);
        int k;
        for (k = 0; k < 300 && ((active_set.inertia_ratio === v) != equal); k++)
            cycles(1);
        if (k == 300)
        begin
            miscompares++;
            stop_test();
        end
    endtask

    initial
    begin
        for (i = 0; i < NUM_PARAMS; i++)
        begin
            nv[i] = 16'h1000 + 16'(i);
            av[i] = 16'h2000 + 16'(i);
        end
        normal_set = gain_set_s'(nv);
        alt_set = gain_set_s'(av);
        rows[0]  = '{16'h0000, 16'h0010, 16'hFFFF, 16'hFFFF, 16'hFFFF, 1'b1, 1'b0};
        rows[1]  = '{16'h0001, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 1'b1, 1'b1};
        rows[2]  = '{16'h0001, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 1'b0, 1'b0};
        rows[3]  = '{16'h0002, 16'h0100, 16'h0100, 16'h0000, 16'h0000, 1'b0, 1'b1};
        rows[4]  = '{16'h0002, 16'h0100, 16'h00FF, 16'hFFFF, 16'hFFFF, 1'b1, 1'b0};
        rows[5]  = '{16'h0012, 16'h0100, 16'h0100, 16'hFFFF, 16'hFFFF, 1'b0, 1'b1};
        rows[6]  = '{16'h0012, 16'h0100, 16'h0101, 16'h0000, 16'h0000, 1'b1, 1'b0};
        rows[7]  = '{16'h0003, 16'h0040, 16'h0000, 16'h0041, 16'h0000, 1'b0, 1'b1};
        rows[8]  = '{16'h0014, 16'h0800, 16'hFFFF, 16'hFFFF, 16'h07FF, 1'b0, 1'b1};
        rows[9]  = '{16'h0004, 16'h0800, 16'hFFFF, 16'hFFFF, 16'h07FF, 1'b0, 1'b0};
        rows[10] = '{16'h0005, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 1'b1, 1'b0};
        rows[11] = '{16'h0011, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 1'b1, 1'b1};
        repeat (16) @(posedge mclk_i);
        #10;
        cmp_set(active_set, '0);
        cmp_bit(alt_active, 1'b0);
        rst_b_i = 1'b1;
        for (i = 0; i < 12; i++)
        begin
            {func, level, freq} = {rows[i].func, rows[i].level, rows[i].freq};
            {droop, speed, request} = {rows[i].droop, rows[i].speed, rows[i].pin};
            cycles(14);
            cmp_bit(alt_active, rows[i].alt);
            cmp_set(active_set, exp_set(rows[i].alt, func[3:0] == 4'h1));
        end
        // slow controller plus a lag filter: value must pass through midway
        {func, request, lag, tc} = {16'h0001, 1'b0, 4'h6, 16'h0002};
        cycles(1);
        wait_inertia(normal_set.inertia_ratio, 1'b1);
        request = 1'b1;
        wait_inertia(normal_set.inertia_ratio, 1'b0);
        cmp_bit(active_set.inertia_ratio > normal_set.inertia_ratio &&
            active_set.inertia_ratio < alt_set.inertia_ratio, 1'b1);
        wait_inertia(alt_set.inertia_ratio, 1'b1);
        cmp_set(active_set, exp_set(1'b1, 1'b1));
        request = 1'b0;
        wait_inertia(normal_set.inertia_ratio, 1'b1);
        cmp_set(active_set, exp_set(1'b0, 1'b1));
        cmp_bit(alt_active, 1'b0);
        // reset in mid-run clears state
        request = 1'b1;
        cycles(20);
        rst_b_i = 1'b0;
        cycles(2);
        cmp_set(active_set, '0);
        cmp_bit(alt_active, 1'b0);
        // after release the pin needs two sync edges and one more to show
        rst_b_i = 1'b1;
        cycles(2);
        cmp_set(active_set, '0);
        cmp_bit(alt_active, 1'b0);
        cycles(1);
        cmp_bit(alt_active, 1'b1);
        stop_test();
    end
endmodule

`default_nettype wire
